// [hdl/iod_decoder.sv]
// Top of the I/O space decoder: direct I/O, data-space alias, bit ops.
// Assumes the core issues at most one access of each kind per cycle and
// holds nothing; the extended range is served by logic outside.
//
// What this block does
// - Direct I/O accesses use 6-bit addresses 0x00..0x3F and select by that alone.
// - Data-space address equal to I/O address plus 0x20 reaches the same register.
// - Extended range 0x60..0xFF is reachable only by data-space load and store.
// - Addresses 0x00..0x1F support single-bit set and clear of one bit.
// - Bit-accessible range supports single-bit test so the core can skip.
// - Some status flags clear on writing one; writing zero leaves them.
// - Bit set or clear touches only the selected bit, no other flag.
`timescale 1ns/10ps
module iod_decoder
	import iod_pkg::*;
(
	input wire logic clock, // core clock, 125 MHz
	input wire logic arst_n, // async reset, active low
	input wire logic [iod_pkg::IOD_IO_AW-1:0] io_addr, // direct I/O address
	input wire logic io_rd, // direct I/O read
	input wire logic io_wr, // direct I/O write
	input wire logic [7:0] io_wdata, // direct I/O write data
	input wire logic set_io_bit_op, // set one bit
	input wire logic clear_io_bit_op, // clear one bit
	input wire logic skip_if_io_bit_set_op, // test, skip when set
	input wire logic skip_if_io_bit_clear_op, // test, skip when clear
	input wire logic [4:0] bit_addr, // bit op address 0x00..0x1F
	input wire logic [2:0] bit_sel, // bit number
	input wire logic [7:0] ds_addr, // data-space address
	input wire logic data_load_op, // data-space load
	input wire logic data_write_op, // data-space store
	input wire logic [7:0] ds_wdata, // data-space store data
	output logic [7:0] rd_data_q, // read data
	output logic rd_valid_q, // read data valid pulse
	output logic skip_q, // skip next instruction
	output logic test_valid_q, // skip_q valid pulse
	output logic ext_rd, // extended range load
	output logic ext_wr, // extended range store
	output logic [7:0] ext_addr, // extended range address
	output logic [7:0] ext_wdata, // extended range store data
	input wire logic [7:0] ext_rdata, // extended range load data
	input wire logic [7:0] port_b_pins, // port B pin levels, async
	input wire logic [7:0] port_c_pins, // port C pin levels, async
	input wire logic [7:0] port_d_pins, // port D pin levels, async
	input wire logic [2:0] port_e_pins, // port E pin levels, async
	input wire logic pll_locked, // PLL lock status
	input wire logic [1:0] spi_status, // transfer done, collision
	input wire logic [2:0] cmp_out, // comparator outputs
	input wire logic [2:0] timer0_flag_set, // timer0 flag events
	input wire logic [3:0] timer1_flag_set, // capture, cmp B, cmp A, overflow
	input wire logic [2:0] cmp_flag_set, // comparator flag events
	output logic [7:0] port_b_direction, // port B direction
	output logic [7:0] port_b_output_latch, // port B output
	output logic [7:0] port_c_direction, // port C direction
	output logic [7:0] port_c_output_latch, // port C output
	output logic [7:0] port_d_direction, // port D direction
	output logic [7:0] port_d_output_latch, // port D output
	output logic [2:0] port_e_direction, // port E direction
	output logic [2:0] port_e_output_latch, // port E output
	output logic [2:0] timer0_flags, // timer0 flags
	output logic [3:0] timer1_flags, // timer1 flags
	output logic [7:0] timer_sync_control, // timer sync control
	output logic [7:0] timer0_control_a, // timer0 control A
	output logic [3:0] timer0_control_b, // timer0 mode and clock select
	output logic [1:0] timer0_force_q, // force compare strobes, pulse
	output logic [7:0] timer0_count, // timer0 count
	output logic [7:0] timer0_compare_a, // timer0 compare A
	output logic [7:0] timer0_compare_b, // timer0 compare B
	output logic [11:0] eeprom_address, // eeprom address
	output logic [7:0] eeprom_data, // eeprom data
	output logic [1:0] pll_control, // PLL factor, enable
	output logic [7:0] serial_port_control, // SPI control
	output logic serial_port_double_speed, // SPI double speed
	output logic [7:0] serial_port_shift_data, // SPI data
	output logic cmp_clock_divide, // comparator clock divide
	output logic [2:0] cmp_flags // comparator flags
);
	import iod_pkg::*;

	// Two-stage synchroniser for all pin inputs
	logic [26:0] pin_meta_q;
	logic [26:0] pin_sync_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {port_e_pins, port_d_pins, port_c_pins, port_b_pins};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Data-space decode; the working register file below 0x20 is not ours
	logic [7:0] ds_off;
	logic ds_in_io;
	logic ds_in_ext;
	logic [5:0] ds_idx;
	assign ds_off = ds_addr - IOD_DS_IO_LO;
	assign ds_idx = ds_off[5:0];
	assign ds_in_io = (ds_addr >= IOD_DS_IO_LO) && (ds_addr <= IOD_DS_IO_HI);
	assign ds_in_ext = ds_addr >= IOD_DS_EXT_LO;

	// Access arbitration: direct I/O, then bit ops, then data space.
	// The core never overlaps them; the order only keeps a glitch harmless.
	logic io_busy;
	logic bit_wr;
	logic bit_test;
	logic bit_any;
	logic ds_ok;
	assign io_busy = io_rd | io_wr;
	assign bit_wr = !io_busy && (set_io_bit_op || clear_io_bit_op);
	assign bit_test = !io_busy && (skip_if_io_bit_set_op || skip_if_io_bit_clear_op);
	assign bit_any = bit_wr | bit_test;
	assign ds_ok = !io_busy && !bit_any;

	// The extended range only ever sees data-space accesses
	assign ext_rd = ds_ok && data_load_op && ds_in_ext;
	assign ext_wr = ds_ok && data_write_op && ds_in_ext;
	assign ext_addr = ds_addr;
	assign ext_wdata = ds_wdata;

	// Unified write: index, value and per-bit mask
	logic acc_wr;
	logic acc_rd;
	logic [5:0] acc_idx;
	logic [7:0] acc_val;
	logic [7:0] acc_mask;
	logic [7:0] bit_onehot;
	assign bit_onehot = 8'h01 << bit_sel;
	assign acc_idx = io_busy ? io_addr : (bit_any ? {1'b0, bit_addr} : ds_idx);
	assign acc_wr = io_wr || bit_wr || (ds_ok && data_write_op && ds_in_io);
	assign acc_rd = io_rd || (ds_ok && data_load_op && ds_in_io);
	// A bit op writes only its own bit, so sibling flags see no write
	assign acc_mask = bit_wr ? bit_onehot : 8'hFF;
	assign acc_val = io_wr ? io_wdata : (bit_wr ? {8{set_io_bit_op}} : ds_wdata);

	// Peripheral inputs that read straight through, and flag set events
	logic [7:0] ro_vec [IOD_IO_DEPTH];
	logic [7:0] hw_set [IOD_IO_DEPTH];
	logic [7:0] reg_q [IOD_IO_DEPTH];
	logic [IOD_IO_DEPTH-1:0] wr_hit;

	genvar i;
	generate
		for (i = 0; i < IOD_IO_DEPTH; i++) begin : g_io
			localparam logic [5:0] A = 6'(i);
			assign ro_vec[i] =
				(A == IOD_PORT_B_PINS) ? pin_sync_q[7:0] :
				(A == IOD_PORT_C_PINS) ? pin_sync_q[15:8] :
				(A == IOD_PORT_D_PINS) ? pin_sync_q[23:16] :
				(A == IOD_PORT_E_PINS) ? {5'h00, pin_sync_q[26:24]} :
				(A == IOD_PLL_CTRL) ? {7'h00, pll_locked} :
				(A == IOD_SPI_STATUS) ? {spi_status, 6'h00} :
				(A == IOD_CMP_CTRL) ? {5'h00, cmp_out} : 8'h00;
			assign hw_set[i] =
				(A == IOD_TIMER0_FLAGS) ? {5'h00, timer0_flag_set} :
				(A == IOD_TIMER1_FLAGS) ?
					{2'b00, timer1_flag_set[3], 2'b00, timer1_flag_set[2:0]} :
				(A == IOD_CMP_CTRL) ? {1'b0, cmp_flag_set, 4'h0} : 8'h00;
			// Reserved addresses have no storage, so a write lands nowhere
			assign wr_hit[i] = acc_wr && (acc_idx == A);
			iod_reg_byte #(
				.RW_MASK(iod_rw_mask(A)),
				.W1C_MASK(iod_w1c_mask(A)),
				.RESET_VAL(IOD_RESET_VAL)
			) u_reg (
				.clock(clock),
				.arst_n(arst_n),
				.wr_en(wr_hit[i]),
				.wr_val(acc_val),
				.wr_mask(acc_mask),
				.hw_set(hw_set[i]),
				.q(reg_q[i])
			);
		end
	endgenerate

	// Read path: reserved bits and addresses hold zero in both sources
	logic [7:0] rd_word;
	logic bit_val;
	logic [7:0] rd_data_d;
	logic rd_valid_d;
	assign rd_word = reg_q[acc_idx] | ro_vec[acc_idx];
	assign bit_val = rd_word[bit_sel];
	assign rd_data_d = ext_rd ? ext_rdata : rd_word;
	assign rd_valid_d = acc_rd || ext_rd;

	// Force strobes are never stored; they pulse for one cycle on write
	logic force_hit;
	logic [1:0] force_d;
	assign force_hit = wr_hit[IOD_TIMER0_CTRL_B];
	assign force_d = force_hit ? (acc_val[7:6] & acc_mask[7:6]) : 2'b00;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			skip_q <= 1'b0;
			test_valid_q <= 1'b0;
			timer0_force_q <= 2'b00;
		end else begin
			rd_data_q <= rd_valid_d ? rd_data_d : 8'h00;
			rd_valid_q <= rd_valid_d;
			skip_q <= bit_test && (skip_if_io_bit_set_op ? bit_val : !bit_val);
			test_valid_q <= bit_test;
			timer0_force_q <= force_d;
		end
	end

	// Register values out to the peripherals
	assign port_b_direction = reg_q[IOD_PORT_B_DIR];
	assign port_b_output_latch = reg_q[IOD_PORT_B_OUT];
	assign port_c_direction = reg_q[IOD_PORT_C_DIR];
	assign port_c_output_latch = reg_q[IOD_PORT_C_OUT];
	assign port_d_direction = reg_q[IOD_PORT_D_DIR];
	assign port_d_output_latch = reg_q[IOD_PORT_D_OUT];
	assign port_e_direction = reg_q[IOD_PORT_E_DIR][2:0];
	assign port_e_output_latch = reg_q[IOD_PORT_E_OUT][2:0];
	assign timer0_flags = reg_q[IOD_TIMER0_FLAGS][2:0];
	assign timer1_flags = {reg_q[IOD_TIMER1_FLAGS][5], reg_q[IOD_TIMER1_FLAGS][2:0]};
	assign timer_sync_control = reg_q[IOD_TIMER_SYNC];
	assign timer0_control_a = reg_q[IOD_TIMER0_CTRL_A];
	assign timer0_control_b = reg_q[IOD_TIMER0_CTRL_B][3:0];
	assign timer0_count = reg_q[IOD_TIMER0_COUNT];
	assign timer0_compare_a = reg_q[IOD_TIMER0_CMP_A];
	assign timer0_compare_b = reg_q[IOD_TIMER0_CMP_B];
	assign eeprom_address = {reg_q[IOD_EEPROM_ADDR_HI][3:0], reg_q[IOD_EEPROM_ADDR_LO]};
	assign eeprom_data = reg_q[IOD_EEPROM_DATA];
	assign pll_control = reg_q[IOD_PLL_CTRL][2:1];
	assign serial_port_control = reg_q[IOD_SPI_CTRL];
	assign serial_port_double_speed = reg_q[IOD_SPI_STATUS][0];
	assign serial_port_shift_data = reg_q[IOD_SPI_DATA];
	assign cmp_clock_divide = reg_q[IOD_CMP_CTRL][7];
	assign cmp_flags = reg_q[IOD_CMP_CTRL][6:4];
endmodule // iod_decoder

// [hdl/iod_pkg.sv]
// Package for the I/O space decoder: offsets, field masks, reset values.
// Assumes a single 125 MHz core clock; nothing here is timing dependent.
package iod_pkg;
	localparam int IOD_DW = 8;
	localparam int IOD_IO_AW = 6;
	localparam int IOD_IO_DEPTH = 64;
	localparam logic [7:0] IOD_DS_IO_LO = 8'h20;
	localparam logic [7:0] IOD_DS_IO_HI = 8'h5F;
	localparam logic [7:0] IOD_DS_EXT_LO = 8'h60;
	localparam logic [7:0] IOD_RESET_VAL = 8'h00;
	localparam logic [5:0] IOD_PORT_B_PINS = 6'h03;
	localparam logic [5:0] IOD_PORT_B_DIR = 6'h04;
	localparam logic [5:0] IOD_PORT_B_OUT = 6'h05;
	localparam logic [5:0] IOD_PORT_C_PINS = 6'h06;
	localparam logic [5:0] IOD_PORT_C_DIR = 6'h07;
	localparam logic [5:0] IOD_PORT_C_OUT = 6'h08;
	localparam logic [5:0] IOD_PORT_D_PINS = 6'h09;
	localparam logic [5:0] IOD_PORT_D_DIR = 6'h0A;
	localparam logic [5:0] IOD_PORT_D_OUT = 6'h0B;
	localparam logic [5:0] IOD_PORT_E_PINS = 6'h0C;
	localparam logic [5:0] IOD_PORT_E_DIR = 6'h0D;
	localparam logic [5:0] IOD_PORT_E_OUT = 6'h0E;
	localparam logic [5:0] IOD_TIMER0_FLAGS = 6'h15;
	localparam logic [5:0] IOD_TIMER1_FLAGS = 6'h16;
	localparam logic [5:0] IOD_SCRATCH_ONE = 6'h19;
	localparam logic [5:0] IOD_SCRATCH_TWO = 6'h1A;
	localparam logic [5:0] IOD_SCRATCH_ZERO = 6'h1E;
	localparam logic [5:0] IOD_EEPROM_DATA = 6'h20;
	localparam logic [5:0] IOD_EEPROM_ADDR_LO = 6'h21;
	localparam logic [5:0] IOD_EEPROM_ADDR_HI = 6'h22;
	localparam logic [5:0] IOD_TIMER_SYNC = 6'h23;
	localparam logic [5:0] IOD_TIMER0_CTRL_A = 6'h24;
	localparam logic [5:0] IOD_TIMER0_CTRL_B = 6'h25;
	localparam logic [5:0] IOD_TIMER0_COUNT = 6'h26;
	localparam logic [5:0] IOD_TIMER0_CMP_A = 6'h27;
	localparam logic [5:0] IOD_TIMER0_CMP_B = 6'h28;
	localparam logic [5:0] IOD_PLL_CTRL = 6'h29;
	localparam logic [5:0] IOD_SPI_CTRL = 6'h2C;
	localparam logic [5:0] IOD_SPI_STATUS = 6'h2D;
	localparam logic [5:0] IOD_SPI_DATA = 6'h2E;
	localparam logic [5:0] IOD_CMP_CTRL = 6'h30;
	// Force strobes in timer0 control B: write-only, always read as zero
	localparam logic [7:0] IOD_T0_FORCE_MASK = 8'hC0;

	// Bits that software stores
	function automatic logic [7:0] iod_rw_mask(input logic [5:0] a);
		case (a)
			IOD_PORT_B_DIR, IOD_PORT_B_OUT, IOD_PORT_C_DIR, IOD_PORT_C_OUT,
			IOD_PORT_D_DIR, IOD_PORT_D_OUT, IOD_SCRATCH_ONE, IOD_SCRATCH_TWO,
			IOD_SCRATCH_ZERO, IOD_EEPROM_DATA, IOD_EEPROM_ADDR_LO, IOD_TIMER0_COUNT,
			IOD_TIMER0_CMP_A, IOD_TIMER0_CMP_B, IOD_SPI_CTRL, IOD_SPI_DATA: return 8'hFF;
			IOD_PORT_E_DIR, IOD_PORT_E_OUT: return 8'h07;
			IOD_EEPROM_ADDR_HI: return 8'h0F;
			IOD_TIMER_SYNC: return 8'hC1;
			IOD_TIMER0_CTRL_A: return 8'hF3;
			IOD_TIMER0_CTRL_B: return 8'h0F;
			IOD_PLL_CTRL: return 8'h06;
			IOD_SPI_STATUS: return 8'h01;
			IOD_CMP_CTRL: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction

	// Status flags set by peripherals and cleared by writing one
	function automatic logic [7:0] iod_w1c_mask(input logic [5:0] a);
		case (a)
			IOD_TIMER0_FLAGS: return 8'h07;
			IOD_TIMER1_FLAGS: return 8'h27;
			IOD_CMP_CTRL: return 8'h70;
			default: return 8'h00;
		endcase
	endfunction
endpackage

// [hdl/iod_reg_byte.sv]
// One byte of the decoded I/O space with per-bit storage kind.
// Assumes write strobe, value and mask come from the same clock domain.
`timescale 1ns/10ps
module iod_reg_byte #(
	parameter logic [7:0] RW_MASK = 8'h00,
	parameter logic [7:0] W1C_MASK = 8'h00,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic clock, // core clock
	input wire logic arst_n, // async reset
	input wire logic wr_en, // write this byte
	input wire logic [7:0] wr_val, // written value
	input wire logic [7:0] wr_mask, // bits touched by the write
	input wire logic [7:0] hw_set, // flag set events
	output logic [7:0] q // stored value
);
	logic [7:0] d;
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			if (RW_MASK[b]) begin : g_rw
				assign d[b] = (wr_en && wr_mask[b]) ? wr_val[b] : q[b];
			end else if (W1C_MASK[b]) begin : g_w1c
				// Set beats a clear in the same cycle so no event is lost
				assign d[b] = hw_set[b] | (q[b] & ~(wr_en & wr_mask[b] & wr_val[b]));
			end else begin : g_none
				assign d[b] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) q <= RESET_VAL;
		else q <= d;
	end
endmodule // iod_reg_byte

// [verification/iod_asserts.sv]
// Checker for the I/O space decoder, bound to the top module's ports.
// Assumes one core clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
module iod_asserts (
	input wire logic clock, // core clock
	input wire logic arst_n, // async reset
	input wire logic [5:0] io_addr, // direct address
	input wire logic io_rd, // direct read
	input wire logic io_wr, // direct write
	input wire logic [7:0] io_wdata, // direct write data
	input wire logic set_io_bit_op, // bit set
	input wire logic clear_io_bit_op, // bit clear
	input wire logic skip_if_io_bit_set_op, // test set
	input wire logic skip_if_io_bit_clear_op, // test clear
	input wire logic [4:0] bit_addr, // bit op address
	input wire logic [2:0] bit_sel, // bit number
	input wire logic [7:0] ds_addr, // data-space address
	input wire logic data_load_op, // load
	input wire logic data_write_op, // store
	input wire logic [7:0] rd_data_q, // read data
	input wire logic rd_valid_q, // read valid
	input wire logic test_valid_q, // test valid
	input wire logic ext_wr, // extended store
	input wire logic [7:0] ext_addr, // extended address
	input wire logic [2:0] timer0_flag_set, // flag events
	input wire logic [2:0] timer0_flags, // timer0 flags
	input wire logic [7:0] port_b_output_latch // port B output
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire io_any = io_rd | io_wr;
	wire bit_wr = set_io_bit_op | clear_io_bit_op;
	wire bit_any = bit_wr | skip_if_io_bit_set_op | skip_if_io_bit_clear_op;
	wire [7:0] onehot = 8'h01 << bit_sel;
	chk_io_read_answer: assert property (io_rd |=> rd_valid_q)
		else $error("direct read got no answer");
	chk_alias_read: assert property (data_load_op && !io_any && !bit_any &&
		ds_addr inside {[8'h20:8'h5F]} |=> rd_valid_q) else $error("alias load got no answer");
	chk_low_ds_dropped: assert property (data_load_op && !io_any && !bit_any &&
		ds_addr < 8'h20 |=> !rd_valid_q) else $error("load below alias answered");
	chk_ext_store_pass: assert property (data_write_op && !io_any && !bit_any &&
		ds_addr >= 8'h60 |-> ext_wr && ext_addr == ds_addr) else $error("ext store lost");
	chk_ext_only_data: assert property (ext_wr |-> data_write_op && ds_addr >= 8'h60)
		else $error("ext store without data-space store");
	chk_test_answer: assert property ((skip_if_io_bit_set_op || skip_if_io_bit_clear_op) &&
		!io_any && !bit_wr |=> test_valid_q) else $error("bit test got no answer");
	chk_flag_w1c: assert property (io_wr && io_addr == 6'h15 |=> timer0_flags ==
		(($past(timer0_flags) & ~$past(io_wdata[2:0])) | $past(timer0_flag_set)))
		else $error("flag write-one-clear wrong");
	chk_bit_flag_only: assert property (set_io_bit_op && !io_any && bit_addr == 5'h15
		|=> timer0_flags == (($past(timer0_flags) & ~$past(onehot[2:0])) | $past(timer0_flag_set)))
		else $error("bit set on flags touched other flags");
	chk_bit_clear_one: assert property (clear_io_bit_op && !io_any && bit_addr == 5'h05
		|=> port_b_output_latch == ($past(port_b_output_latch) & ~$past(onehot)))
		else $error("bit clear changed wrong bits");
	chk_reserved_zero: assert property (io_rd && io_addr inside {[6'h00:6'h02],
		[6'h0F:6'h14]} |=> rd_data_q == 8'h00) else $error("reserved read not zero");
endmodule // iod_asserts

// [verification/iod_ext_model.sv]
// Model of the extended-range registers that sit behind the decoder.
// Assumes loads are answered in the request cycle and stores land on the edge.
`timescale 1ns/10ps
module iod_ext_model (
	input wire logic clock, // core clock
	input wire logic ext_rd, // load strobe
	input wire logic ext_wr, // store strobe
	input wire logic [7:0] ext_addr, // address
	input wire logic [7:0] ext_wdata, // store data
	output logic [7:0] ext_rdata // load data
);
	logic [7:0] mem [256];
	logic [7:0] last_q = 8'h00;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
	end
	always @(posedge clock) begin
		if (ext_wr && ext_addr >= 8'h60) mem[ext_addr] <= ext_wdata;
		if (ext_rd) last_q <= mem[ext_addr];
	end
	// Idle bus shows the inverse of the last load so stale data never passes
	assign ext_rdata = ext_rd ? mem[ext_addr] : ~last_q;
endmodule // iod_ext_model

// [verification/tb_io_space_decoder.sv]
// Self-checking bench for the I/O space decoder with an extended-range model.
// Assumes reads and bit tests are answered exactly one cycle after the request.
`timescale 1ns/10ps
module tb_io_space_decoder;
	import iod_pkg::*;
	localparam logic [7:0] K_IRD = 8'h01, K_IWR = 8'h02, K_LD = 8'h04, K_ST = 8'h08;
	localparam logic [7:0] K_SET = 8'h10, K_CLR = 8'h20, K_TS = 8'h40, K_TC = 8'h80;
	logic clock, arst_n, io_rd, io_wr, set_io_bit_op, clear_io_bit_op, pll_locked;
	logic skip_if_io_bit_set_op, skip_if_io_bit_clear_op, data_load_op, data_write_op;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, ds_addr, ds_wdata, port_b_pins, port_c_pins, port_d_pins;
	logic [4:0] bit_addr;
	logic [2:0] bit_sel, port_e_pins, cmp_out, timer0_flag_set, cmp_flag_set;
	logic [1:0] spi_status;
	logic [3:0] timer1_flag_set;
	wire [7:0] rd_data_q, ext_addr, ext_wdata, ext_rdata, port_b_output_latch;
	wire rd_valid_q, skip_q, test_valid_q, ext_rd, ext_wr;
	wire [2:0] timer0_flags, cmp_flags;
	wire [3:0] timer1_flags, timer0_control_b;
	wire [1:0] timer0_force_q;
	wire [11:0] eeprom_address;
	int error_cnt = 0;
	int check_count = 0;
	int ext_wr_seen = 0;
	iod_decoder iod_decoder_i (.clock, .arst_n, .io_addr, .io_rd, .io_wr, .io_wdata,
		.set_io_bit_op, .clear_io_bit_op, .skip_if_io_bit_set_op, .skip_if_io_bit_clear_op,
		.bit_addr, .bit_sel, .ds_addr, .data_load_op, .data_write_op, .ds_wdata, .rd_data_q,
		.rd_valid_q, .skip_q, .test_valid_q, .ext_rd, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata,
		.port_b_pins, .port_c_pins, .port_d_pins, .port_e_pins, .pll_locked, .spi_status, .cmp_out,
		.timer0_flag_set, .timer1_flag_set, .cmp_flag_set, .port_b_direction(),
		.port_b_output_latch, .port_c_direction(), .port_c_output_latch(), .port_d_direction(),
		.port_d_output_latch(), .port_e_direction(), .port_e_output_latch(), .timer0_flags,
		.timer1_flags, .timer_sync_control(), .timer0_control_a(), .timer0_control_b,
		.timer0_force_q, .timer0_count(), .timer0_compare_a(), .timer0_compare_b(),
		.eeprom_address, .eeprom_data(), .pll_control(), .serial_port_control(),
		.serial_port_double_speed(), .serial_port_shift_data(), .cmp_clock_divide(), .cmp_flags);
	iod_ext_model iod_ext_model_i (.clock, .ext_rd, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) if (ext_wr) ext_wr_seen++;
	task automatic step();
		@(posedge clock);
		#1;
	endtask
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Every strobe is assigned once per request, so back-to-back requests stay one cycle each
	task automatic req(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
		{skip_if_io_bit_clear_op, skip_if_io_bit_set_op, clear_io_bit_op, set_io_bit_op} = k[7:4];
		{data_write_op, data_load_op, io_wr, io_rd} = k[3:0];
		{io_addr, bit_addr, ds_addr} = {a[5:0], a[4:0], a};
		{io_wdata, ds_wdata, bit_sel} = {d, d, d[2:0]};
		step();
	endtask
	task automatic rd(input logic [7:0] k, input logic [7:0] a, input logic [7:0] exp);
		req(k, a, 8'h00);
		check8("read valid", 8'h01, {7'h0, rd_valid_q});
		check8("read data", exp, rd_data_q);
	endtask
	task automatic tst(input logic [7:0] k, input logic [7:0] a, input logic [7:0] b, input logic e);
		req(k, a, b);
		check8("test valid", 8'h01, {7'h0, test_valid_q});
		check8("skip", {7'h0, e}, {7'h0, skip_q});
	endtask
	task automatic t_map();
		logic [7:0] regs [8] = '{8'h04, 8'h05, 8'h07, 8'h0B, 8'h19, 8'h1E, 8'h26, 8'h28};
		foreach (regs[i]) rd(K_IRD, regs[i], 8'h00);
		// Only mapped full-width registers are written here
		foreach (regs[i]) req(K_IWR, regs[i], 8'hA5 ^ regs[i]);
		foreach (regs[i]) rd(K_LD, regs[i] + 8'h20, 8'hA5 ^ regs[i]);
		foreach (regs[i]) req(K_ST, regs[i] + 8'h20, regs[i]);
		foreach (regs[i]) rd(K_IRD, regs[i], regs[i]);
		check8("port b latch", 8'h05, port_b_output_latch);
		req(K_LD, 8'h1F, 8'h00);
		check8("low load valid", 8'h00, {7'h0, rd_valid_q});
		$display("test map done");
	endtask
	task automatic t_ext();
		req(K_ST, 8'h80, 8'h96);
		req(K_ST, 8'h5F, 8'h11);
		rd(K_LD, 8'h80, 8'h96);
		rd(K_LD, 8'h60, 8'h60 ^ 8'hC3);
		rd(K_LD, 8'hFF, 8'hFF ^ 8'hC3);
		check8("ext stores", 8'h01, 8'(ext_wr_seen));
		$display("test ext done");
	endtask
	task automatic t_bits();
		logic [7:0] exp = 8'h00;
		logic [7:0] pa [4] = '{8'h03, 8'h06, 8'h09, 8'h0C};
		logic [7:0] pv [4] = '{8'h5A, 8'hA5, 8'h3C, 8'h05};
		req(K_IWR, 8'h05, 8'h00);
		for (int i = 0; i < 8; i++) begin
			exp[i] = 1'b1;
			req(K_SET, 8'h05, 8'(i));
			check8("bit set", exp, port_b_output_latch);
		end
		for (int i = 7; i >= 0; i -= 2) begin
			exp[i] = 1'b0;
			req(K_CLR, 8'h05, 8'(i));
			check8("bit clear", exp, port_b_output_latch);
		end
		{port_b_pins, port_c_pins, port_d_pins, port_e_pins} = {pv[0], pv[1], pv[2], pv[3][2:0]};
		repeat (3) req(8'h00, 8'h00, 8'h00);
		foreach (pa[j]) for (int i = 0; i < 8; i++) begin
			tst(K_TS, pa[j], 8'(i), pv[j][i]);
			tst(K_TC, pa[j], 8'(i), !pv[j][i]);
		end
		$display("test bits done");
	endtask
	task automatic t_flags();
		{timer0_flag_set, timer1_flag_set} = {3'h7, 4'hF};
		step();
		{timer0_flag_set, timer1_flag_set} = 7'h00;
		step();
		check8("t0 flags set", 8'h07, {5'h0, timer0_flags});
		req(K_IWR, 8'h15, 8'h00);
		check8("t0 write zero", 8'h07, {5'h0, timer0_flags});
		req(K_SET, 8'h15, 8'h01);
		check8("t0 bit set", 8'h05, {5'h0, timer0_flags});
		req(K_CLR, 8'h15, 8'h00);
		check8("t0 bit clear", 8'h05, {5'h0, timer0_flags});
		req(K_IWR, 8'h15, 8'h04);
		check8("t0 write one", 8'h01, {5'h0, timer0_flags});
		// An event in the clearing cycle must not be lost
		timer0_flag_set = 3'h1;
		req(K_IWR, 8'h15, 8'h01);
		timer0_flag_set = 3'h0;
		check8("t0 set wins", 8'h01, {5'h0, timer0_flags});
		req(K_IWR, 8'h16, 8'h20);
		check8("t1 flags", 8'h07, {4'h0, timer1_flags});
		rd(K_IRD, 8'h16, 8'h07);
		rd(K_LD, 8'h35, 8'h01);
		$display("test flags done");
	endtask
	task automatic t_periph();
		req(K_IWR, 8'h25, 8'hC3);
		check8("force pulse", 8'h03, {6'h0, timer0_force_q});
		check8("t0 ctrl b", 8'h03, {4'h0, timer0_control_b});
		rd(K_IRD, 8'h25, 8'h03);
		check8("force ends", 8'h00, {6'h0, timer0_force_q});
		req(K_IWR, 8'h21, 8'h34);
		req(K_ST, 8'h42, 8'h09);
		check8("ee addr hi", 8'h09, {4'h0, eeprom_address[11:8]});
		check8("ee addr lo", 8'h34, eeprom_address[7:0]);
		{pll_locked, spi_status, cmp_out} = {1'b1, 2'b10, 3'h5};
		rd(K_IRD, 8'h29, 8'h01);
		rd(K_LD, 8'h4D, 8'h80);
		rd(K_IRD, 8'h30, 8'h05);
		cmp_flag_set = 3'h6;
		step();
		cmp_flag_set = 3'h0;
		req(K_IWR, 8'h30, 8'h20);
		check8("cmp flags", 8'h04, {5'h0, cmp_flags});
		$display("test periph done");
	endtask
	task automatic t_reserved();
		req(K_IWR, 8'h19, 8'h77);
		req(K_IWR, 8'h10, 8'hFF);
		req(K_IWR, 8'h01, 8'hFF);
		req(K_ST, 8'h34, 8'hFF);
		rd(K_IRD, 8'h10, 8'h00);
		rd(K_IRD, 8'h01, 8'h00);
		rd(K_IRD, 8'h14, 8'h00);
		rd(K_IRD, 8'h19, 8'h77);
		check8("latch kept", 8'h55, port_b_output_latch);
		req(8'h00, 8'h00, 8'h00);
		$display("test reserved done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		{io_rd, io_wr, set_io_bit_op, clear_io_bit_op, pll_locked, io_addr, io_wdata} = '0;
		{skip_if_io_bit_set_op, skip_if_io_bit_clear_op, data_load_op, data_write_op} = '0;
		{ds_addr, ds_wdata, bit_addr, bit_sel, port_b_pins, port_c_pins, port_d_pins} = '0;
		{port_e_pins, cmp_out, timer0_flag_set, cmp_flag_set, spi_status, timer1_flag_set} = '0;
		repeat (20) @(posedge clock);
		#1 arst_n = 1'b1;
		step();
		t_map();
		t_ext();
		t_bits();
		t_flags();
		t_periph();
		t_reserved();
		conclude();
	end
	initial begin
		#40000;
		error_cnt++;
		$display("ERROR watchdog expected end seen timeout");
		conclude();
	end
endmodule // tb_io_space_decoder
bind iod_decoder iod_asserts iod_asserts_i (.clock, .arst_n, .io_addr, .io_rd, .io_wr, .io_wdata,
	.set_io_bit_op, .clear_io_bit_op, .skip_if_io_bit_set_op, .skip_if_io_bit_clear_op,
	.bit_addr, .bit_sel, .ds_addr, .data_load_op, .data_write_op, .rd_data_q, .rd_valid_q,
	.test_valid_q, .ext_wr, .ext_addr, .timer0_flag_set, .timer0_flags, .port_b_output_latch);
